// ==== verilog/sync_serial_pkg.sv ====
// Constants shared by the synchronous serial port: register map and fields.
package sync_serial_pkg;

  // ----------------------------------------------------------------------
  // Data and level widths
  // ----------------------------------------------------------------------
  localparam int          WORD_W = 16;
  localparam int          LVL_W  = 4;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_WMARK  = 8'h04;
  localparam logic [7:0]  OFS_STATUS = 8'h08;
  localparam logic [7:0]  OFS_TXDATA = 8'h0C;
  localparam logic [7:0]  OFS_RXDATA = 8'h10;

  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int          B_PORT_EN    = 0;
  localparam int          B_TX_EN      = 1;
  localparam int          B_RX_EN      = 2;
  localparam int          B_TX_FIFO_EN = 3;
  localparam int          B_RX_FIFO_EN = 4;
  localparam int          B_TX_IRQ_EN  = 5;
  localparam int          B_RX_IRQ_EN  = 6;
  localparam int          B_WL_LO      = 8;
  localparam int          B_SLOTS_LO   = 12;
  localparam logic [31:0] CTRL_MASK    = 32'h0001_F37F;
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Watermark register fields
  // ----------------------------------------------------------------------
  localparam int          B_TX_WM_LO  = 0;
  localparam int          B_RX_WM_LO  = 8;
  localparam logic [31:0] WMARK_MASK  = 32'h0000_0F0F;
  localparam logic [31:0] WMARK_RESET = 32'h0000_0404;

  // ----------------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------------
  localparam int          B_TX_EMPTY   = 0;
  localparam int          B_TX_FEMPTY  = 1;
  localparam int          B_TX_UNDER   = 2;
  localparam int          B_RX_READY   = 3;
  localparam int          B_RX_FFULL   = 4;
  localparam int          B_RX_OVER    = 5;
  localparam int          B_TX_LVL_LO  = 8;
  localparam int          B_RX_LVL_LO  = 12;

  // Word length code to bit count.
  function automatic logic [4:0] wl_bits(input logic [1:0] code);
    unique case (code)
      2'h0: wl_bits = 5'h08;
      2'h1: wl_bits = 5'h0A;
      2'h2: wl_bits = 5'h0C;
      2'h3: wl_bits = 5'h10;
    endcase
  endfunction : wl_bits

endpackage : sync_serial_pkg

// ==== verilog/sync_serial_port.sv ====
// Normal-mode synchronous serial port with AHB-Lite register access.
//
// How it works
// - Transmit interrupt follows empty flag, or FIFO empty flag in FIFO mode, when enabled.
// - Shift transmit register on transmit clock rise.
// - Release data output after word length bits.
// - Drive data output only while sending.
// - Flag under-run when no fresh word at sync once transmitter running.
// - Reception starts only at next frame sync.
// - Receive FIFO level compared with watermark.
// - Receive frame starts at frame sync edge.
// - Shift receive bit on receive clock fall.
// - Move full word into receive data store.
// - Load happens mid final bit, not end.
// - Set ready flag or FIFO full flag.
// - Receive interrupt follows ready flag, or FIFO full flag in FIFO mode, when enabled.
// - Flag over-run when receive store full.
// - Each direction rearms on next frame sync.
// - Transmitter starts at sync once data loaded.
// - Set empty flag when word moves out.
// - Only first slot carries data.
`timescale 1ns/100ps

module sync_serial_port #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial link
  input  wire logic        tx_bit_clock,
  input  wire logic        tx_frame_sync,
  output logic             tx_serial_out,
  output logic             tx_serial_oe_n,
  input  wire logic        rx_bit_clock,
  input  wire logic        rx_frame_sync,
  input  wire logic        rx_serial_in,
  // Interrupt requests
  output logic             tx_irq,
  output logic             rx_irq
);
  import sync_serial_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                        tclk_s;
    logic [2:0]                        tfs_s;
    logic [2:0]                        rclk_s;
    logic [2:0]                        rfs_s;
    logic [1:0]                        rdin_s;
    logic [31:0]                       ctrl;
    logic [31:0]                       wmark;
    logic [TX_DEPTH-1:0][WORD_W-1:0]   tx_mem;
    logic [LVL_W-1:0]                  tx_lvl;
    logic [RX_DEPTH-1:0][WORD_W-1:0]   rx_mem;
    logic [LVL_W-1:0]                  rx_lvl;
    logic                              tx_under;
    logic                              rx_over;
    logic                              tx_run;
    logic                              tx_act;
    logic [4:0]                        tx_cnt;
    logic [WORD_W-1:0]                 tx_sr;
    logic [WORD_W-1:0]                 tx_last;
    logic                              rx_act;
    logic [4:0]                        rx_cnt;
    logic [WORD_W-1:0]                 rx_sr;
    logic                              dp_wr;
    logic                              dp_rd;
    logic [7:0]                        dp_addr;
    logic [31:0]                       rdata;
  } state_t;

  state_t q;
  state_t d;

  // ----------------------------------------------------------------------
  // Decoded controls and edges
  // ----------------------------------------------------------------------
  logic             port_en;
  logic             tx_fifo_en;
  logic             rx_fifo_en;
  logic [4:0]       wl;
  logic [LVL_W-1:0] tx_cap;
  logic [LVL_W-1:0] rx_cap;
  logic [LVL_W-1:0] tx_wm;
  logic [LVL_W-1:0] rx_wm;
  logic             tx_rise;
  logic             tfs_edge;
  logic             rx_fall;
  logic             rfs_edge;
  logic             tx_data_empty_flag;
  logic             tx_fifo_empty_flag;
  logic             rx_data_ready_flag;
  logic             rx_fifo_full_flag;
  logic             accept;
  logic             set_under;
  logic             set_over;
  logic             clr_under;
  logic             clr_over;
  logic [WORD_W-1:0] rx_word;
  logic [WORD_W-1:0] tx_word;

  assign port_en    = q.ctrl[B_PORT_EN];
  assign tx_fifo_en = q.ctrl[B_TX_FIFO_EN];
  assign rx_fifo_en = q.ctrl[B_RX_FIFO_EN];
  assign wl         = wl_bits(q.ctrl[B_WL_LO +: 2]);
  assign tx_cap     = tx_fifo_en ? LVL_W'(TX_DEPTH) : LVL_W'(1);
  assign rx_cap     = rx_fifo_en ? LVL_W'(RX_DEPTH) : LVL_W'(1);
  assign tx_wm      = q.wmark[B_TX_WM_LO +: LVL_W];
  assign rx_wm      = q.wmark[B_RX_WM_LO +: LVL_W];
  assign tx_rise    = q.tclk_s[1] & ~q.tclk_s[2];
  assign tfs_edge   = q.tfs_s[1] & ~q.tfs_s[2];
  assign rx_fall    = ~q.rclk_s[1] & q.rclk_s[2];
  assign rfs_edge   = q.rfs_s[1] & ~q.rfs_s[2];
  assign rx_word    = {q.rx_sr[WORD_W-2:0], q.rdin_s[1]};
  assign tx_word    = (q.tx_lvl == '0) ? q.tx_last : q.tx_mem[0];
  assign accept     = hsel & hready & htrans[1];

  // Flags are levels of the stores, so they set as a word moves.
  assign tx_data_empty_flag = (q.tx_lvl == '0);
  assign tx_fifo_empty_flag = (q.tx_lvl < tx_wm);
  assign rx_data_ready_flag = (q.rx_lvl != '0);
  assign rx_fifo_full_flag  = (q.rx_lvl > rx_wm);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    d         = q;
    set_under = 1'b0;
    set_over  = 1'b0;
    clr_under = 1'b0;
    clr_over  = 1'b0;
    d.tclk_s  = {q.tclk_s[1:0], tx_bit_clock};
    d.tfs_s   = {q.tfs_s[1:0], tx_frame_sync};
    d.rclk_s  = {q.rclk_s[1:0], rx_bit_clock};
    d.rfs_s   = {q.rfs_s[1:0], rx_frame_sync};
    d.rdin_s  = {q.rdin_s[0], rx_serial_in};

    // Transmitter.
    if (!port_en || !q.ctrl[B_TX_EN]) begin
      d.tx_run = 1'b0;
    end
    if (tx_rise && q.tx_act) begin
      if (q.tx_cnt == wl) begin
        d.tx_act = 1'b0;
      end else begin
        d.tx_sr  = {q.tx_sr[WORD_W-2:0], 1'b0};
        d.tx_cnt = q.tx_cnt + 5'h01;
      end
    end
    // A sync inside a word is ignored; frame length is the far end's.
    if (tfs_edge && !q.tx_act && port_en && q.ctrl[B_TX_EN]) begin
      if (q.tx_run || q.tx_lvl != '0) begin
        d.tx_run = 1'b1;
        d.tx_act = 1'b1;
        d.tx_cnt = 5'h01;
        d.tx_sr  = tx_word << (5'(WORD_W) - wl);
        if (q.tx_lvl == '0) begin
          set_under = 1'b1;
        end else begin
          d.tx_last = q.tx_mem[0];
          for (int i = 0; i < TX_DEPTH - 1; i++) begin
            d.tx_mem[i] = q.tx_mem[i+1];
          end
          d.tx_lvl = q.tx_lvl - LVL_W'(1);
        end
      end
    end

    // Receiver.
    if (rx_fall && q.rx_act) begin
      d.rx_sr  = rx_word;
      d.rx_cnt = q.rx_cnt + 5'h01;
      // The store loads on the edge that samples the last bit.
      if (q.rx_cnt + 5'h01 == wl) begin
        d.rx_act = 1'b0;
        if (q.rx_lvl < rx_cap) begin
          d.rx_mem[q.rx_lvl] = rx_word;
          d.rx_lvl = q.rx_lvl + LVL_W'(1);
        end else begin
          set_over = 1'b1;
        end
      end
    end
    if (rfs_edge && !q.rx_act && port_en && q.ctrl[B_RX_EN]) begin
      d.rx_act = 1'b1;
      d.rx_cnt = 5'h00;
      d.rx_sr  = '0;
    end

    // Bus data phase of a write.
    if (q.dp_wr) begin
      unique case (q.dp_addr)
        OFS_CTRL:   d.ctrl  = hwdata & CTRL_MASK;
        OFS_WMARK:  d.wmark = hwdata & WMARK_MASK;
        OFS_STATUS: begin
          clr_under = hwdata[B_TX_UNDER];
          clr_over  = hwdata[B_RX_OVER];
        end
        OFS_TXDATA: begin
          if (d.tx_lvl < tx_cap) begin
            d.tx_mem[d.tx_lvl] = hwdata[WORD_W-1:0];
            d.tx_lvl = d.tx_lvl + LVL_W'(1);
          end else if (!tx_fifo_en) begin
            d.tx_mem[0] = hwdata[WORD_W-1:0];
          end
        end
        default: ;
      endcase
    end

    // Bus data phase of a read, one wait state.
    if (q.dp_rd) begin
      d.rdata = 32'h0000_0000;
      unique case (q.dp_addr)
        OFS_CTRL:   d.rdata = q.ctrl;
        OFS_WMARK:  d.rdata = q.wmark;
        OFS_STATUS: begin
          d.rdata[B_TX_EMPTY]             = tx_data_empty_flag;
          d.rdata[B_TX_FEMPTY]            = tx_fifo_empty_flag;
          d.rdata[B_TX_UNDER]             = q.tx_under;
          d.rdata[B_RX_READY]             = rx_data_ready_flag;
          d.rdata[B_RX_FFULL]             = rx_fifo_full_flag;
          d.rdata[B_RX_OVER]              = q.rx_over;
          d.rdata[B_TX_LVL_LO +: LVL_W]   = q.tx_lvl;
          d.rdata[B_RX_LVL_LO +: LVL_W]   = q.rx_lvl;
        end
        OFS_RXDATA: begin
          if (d.rx_lvl != '0) begin
            d.rdata[WORD_W-1:0] = d.rx_mem[0];
            for (int i = 0; i < RX_DEPTH - 1; i++) begin
              d.rx_mem[i] = d.rx_mem[i+1];
            end
            d.rx_lvl = d.rx_lvl - LVL_W'(1);
          end
        end
        default: ;
      endcase
    end

    // Bus address phase.
    d.dp_wr   = accept & hwrite;
    d.dp_rd   = accept & ~hwrite;
    d.dp_addr = haddr[7:0];

    // A new error wins over a clear in the same cycle.
    d.tx_under = (q.tx_under & ~clr_under) | set_under;
    d.rx_over  = (q.rx_over & ~clr_over) | set_over;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q       <= '0;
      q.ctrl  <= CTRL_RESET;
      q.wmark <= WMARK_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign hreadyout      = ~q.dp_rd;
  assign hresp          = 1'b0;
  assign hrdata         = q.rdata;
  assign tx_serial_out  = q.tx_act & q.tx_sr[WORD_W-1];
  assign tx_serial_oe_n = ~q.tx_act;
  assign tx_irq = q.ctrl[B_TX_IRQ_EN] &
                  (tx_fifo_en ? tx_fifo_empty_flag : tx_data_empty_flag);
  assign rx_irq = q.ctrl[B_RX_IRQ_EN] &
                  (rx_fifo_en ? rx_fifo_full_flag : rx_data_ready_flag);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_OE_IDLE: assert property (!q.tx_act |-> tx_serial_oe_n)
    else $error("data output enabled outside a word");
  AST_TX_SHIFT: assert property (
    tx_rise && q.tx_act && q.tx_cnt != wl && !tfs_edge
    |=> q.tx_sr == {$past(q.tx_sr[WORD_W-2:0]), 1'b0})
    else $error("transmit register did not shift on clock rise");
  AST_TX_END: assert property (
    tx_rise && q.tx_act && q.tx_cnt == wl |=> tx_serial_oe_n)
    else $error("data output not released after last bit");
  AST_UNDER: assert property (
    tfs_edge && !q.tx_act && q.tx_run && q.tx_lvl == '0 && port_en
    && q.ctrl[B_TX_EN] |=> q.tx_under)
    else $error("under-run not flagged");
  AST_RX_WAIT: assert property (
    !q.rx_act && !rfs_edge |=> !q.rx_act)
    else $error("reception began without a frame sync");
  AST_RX_LOAD: assert property (
    rx_fall && q.rx_act && q.rx_cnt + 5'h01 == wl && q.rx_lvl < rx_cap
    && !q.dp_rd |=> q.rx_lvl == $past(q.rx_lvl) + LVL_W'(1))
    else $error("received word not stored");
  AST_OVER: assert property (
    rx_fall && q.rx_act && q.rx_cnt + 5'h01 == wl && q.rx_lvl == rx_cap
    && !q.dp_rd |=> q.rx_over)
    else $error("over-run not flagged");
  AST_STICKY: assert property (
    q.rx_over && !(q.dp_wr && q.dp_addr == OFS_STATUS)
    |=> q.rx_over)
    else $error("over-run flag dropped without a clear");
  AST_UNDER_HOLD: assert property (
    q.tx_under && !(q.dp_wr && q.dp_addr == OFS_STATUS) |=> q.tx_under)
    else $error("under-run flag dropped without a clear");
  AST_TX_START: assert property (
    !q.tx_act && !q.tx_run && q.tx_lvl == '0 |=> !q.tx_act)
    else $error("transmitter started with nothing loaded");
  AST_TX_LOAD: assert property (
    tfs_edge && !q.tx_act && port_en && q.ctrl[B_TX_EN] && q.tx_lvl != '0
    && !q.dp_wr |=> q.tx_lvl == $past(q.tx_lvl) - LVL_W'(1))
    else $error("transmit word not taken from the store");
  AST_RX_ARM: assert property (
    rfs_edge && !q.rx_act && port_en && q.ctrl[B_RX_EN]
    |=> q.rx_act && q.rx_cnt == 5'h00)
    else $error("receive frame not armed at frame sync");
  AST_RX_SHIFT: assert property (
    rx_fall && q.rx_act
    |=> q.rx_sr == {$past(q.rx_sr[WORD_W-2:0]), $past(q.rdin_s[1])})
    else $error("receive register did not shift on clock fall");
  AST_RX_IRQ: assert property (
    $rose(rx_data_ready_flag) && q.ctrl[B_RX_IRQ_EN] && !rx_fifo_en
    |-> rx_irq)
    else $error("receive interrupt missing");

endmodule : sync_serial_port

// ==== testbench/codec_model.sv ====
// Behavioural far-end codec that drives the link and captures sent words.
`timescale 1ns/100ps

module codec_model (
  // Transmit side of the link
  output logic      tx_bit_clock,
  output logic      tx_frame_sync,
  input  wire logic tx_serial_out,
  input  wire logic tx_serial_oe_n,
  // Receive side of the link
  output logic      rx_bit_clock,
  output logic      rx_frame_sync,
  output logic      rx_serial_in
);
  localparam realtime HALF = 62.5;

  logic bclk;
  logic fsync;

  // Both directions share one clock and sync; it stands still between frames.
  assign tx_bit_clock  = bclk;
  assign rx_bit_clock  = bclk;
  assign tx_frame_sync = fsync;
  assign rx_frame_sync = fsync;

  initial begin
    bclk         = 1'b0;
    fsync        = 1'b0;
    rx_serial_in = 1'b0;
  end

  // ----------------------------------------------------------------------
  // One frame: returns the captured word, and in st bit 0 that the output
  // was driven for every bit and released after, in bit 1 that it was
  // driven at all.
  // ----------------------------------------------------------------------
  task automatic frame(input int wl, input logic [15:0] rw,
                       output logic [15:0] tw, output logic [1:0] st);
    int i;
    tw = 16'h0000;
    st = 2'h1;
    #3.1;
    fsync = 1'b1;
    for (i = 0; i < wl; i++) begin
      #(HALF);
      tw    = {tw[14:0], tx_serial_out};
      st[0] = st[0] & (tx_serial_oe_n === 1'b0);
      st[1] = st[1] | (tx_serial_oe_n === 1'b0);
      bclk  = 1'b1;
      fsync = 1'b0;
      // Data changes on the rise and holds across the sampling fall.
      rx_serial_in = rw[wl-1-i];
      #(HALF);
      bclk = 1'b0;
    end
    #(HALF);
    // The line is released: show the inverse of the last bit.
    rx_serial_in = ~rx_serial_in;
    st[0] = st[0] & (tx_serial_oe_n === 1'b1) & (tx_serial_out === 1'b0);
    #(8 * HALF);
  endtask : frame

endmodule : codec_model

// ==== testbench/tb.sv ====
// Self-checking bench for the synchronous serial port.
`timescale 1ns/100ps

module tb;
  import sync_serial_pkg::*;

  localparam int NB [4] = '{8, 10, 12, 16};

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        tx_bit_clock;
  logic        tx_frame_sync;
  logic        tx_serial_out;
  logic        tx_serial_oe_n;
  logic        rx_bit_clock;
  logic        rx_frame_sync;
  logic        rx_serial_in;
  logic        tx_irq;
  logic        rx_irq;
  int          err_count;
  int          checked;
  int          cyc;

  sync_serial_port sync_serial_port_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .tx_serial_out(tx_serial_out), .tx_serial_oe_n(tx_serial_oe_n),
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .rx_serial_in(rx_serial_in), .tx_irq(tx_irq), .rx_irq(rx_irq)
  );

  codec_model codec_model_i (
    .tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
    .tx_serial_out(tx_serial_out), .tx_serial_oe_n(tx_serial_oe_n),
    .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
    .rx_serial_in(rx_serial_in)
  );

  initial hclk = 1'b0;
  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Bus master: one single word transfer, address then data phase.
  // ----------------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    // Let this edge's register updates land before anything is compared.
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask : rd_chk

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int          c;
    logic [15:0] tw;
    logic [15:0] pat;
    logic [15:0] rp;
    logic [1:0]  st;
    logic [31:0] m;
    err_count = 0;
    checked   = 0;
    cyc       = 0;
    hresetn   = 1'b0;
    hsel      = 1'b1;
    hwrite    = 1'b0;
    htrans    = 2'h0;
    hsize     = 3'h2;
    haddr     = 32'h0000_0000;
    hwdata    = 32'h0000_0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    rd_chk(OFS_CTRL, CTRL_RESET);
    rd_chk(OFS_WMARK, WMARK_RESET);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h0000_0000);
    chk(32'(hresp), 32'h0000_0000);
    done("reset");
    // Enabled but nothing loaded: the pin stays released.
    wr(OFS_CTRL, 32'h0000_0003);
    codec_model_i.frame(8, 16'h005A, tw, st);
    chk(32'(st), 32'h0000_0000);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    done("idle");
    for (c = 0; c < 4; c++) begin
      m   = (32'h1 << NB[c]) - 32'h1;
      pat = 16'hB38D + 16'(c);
      rp  = ~pat;
      wr(OFS_CTRL, 32'h0000_0067 | (32'(c) << B_WL_LO));
      wr(OFS_TXDATA, {16'h0000, pat});
      chk(32'(tx_irq), 32'h0000_0000);
      codec_model_i.frame(NB[c], rp, tw, st);
      chk(32'(tw), pat & m);
      chk(32'(st), 32'h0000_0003);
      chk(32'({tx_irq, rx_irq}), 32'h0000_0003);
      rd_chk(OFS_STATUS, 32'h0000_100B);
      rd_chk(OFS_RXDATA, rp & m);
      chk(32'(rx_irq), 32'h0000_0000);
    end
    done("word_length");
    codec_model_i.frame(16, 16'h1234, tw, st);
    chk(32'(tw), 32'(pat));
    rd_chk(OFS_STATUS, 32'h0000_100F);
    codec_model_i.frame(16, 16'hFEDC, tw, st);
    rd_chk(OFS_STATUS, 32'h0000_102F);
    rd_chk(OFS_RXDATA, 32'h0000_1234);
    wr(OFS_STATUS, 32'h0000_0024);
    rd_chk(OFS_STATUS, 32'h0000_0003);
    done("errors");
    wr(OFS_WMARK, 32'h0000_0101);
    wr(OFS_CTRL, 32'h0000_037F);
    wr(OFS_TXDATA, 32'h0000_C001);
    wr(OFS_TXDATA, 32'h0000_C002);
    rd_chk(OFS_STATUS, 32'h0000_0200);
    codec_model_i.frame(16, 16'h0A0A, tw, st);
    chk(32'(tw), 32'h0000_C001);
    rd_chk(OFS_STATUS, 32'h0000_1108);
    chk(32'({tx_irq, rx_irq}), 32'h0000_0000);
    codec_model_i.frame(16, 16'h0B0B, tw, st);
    chk(32'(tw), 32'h0000_C002);
    rd_chk(OFS_STATUS, 32'h0000_201B);
    chk(32'({tx_irq, rx_irq}), 32'h0000_0003);
    rd_chk(OFS_RXDATA, 32'h0000_0A0A);
    rd_chk(OFS_RXDATA, 32'h0000_0B0B);
    done("fifo");
    conclude();
  end

endmodule : tb
